/* File: csr_pkg.sv */
// Shared constants for the power/driver area register and the CSR decode.
// Assumes a single host-side clock and a simplified host access bus.
package csr_pkg;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned CSR_COUNT     = 16;
  localparam int unsigned CSR_IDX_W     = 4;
  // Offsets of the sixteen control/status registers
  localparam logic [7:0] OFF_BUS_MODE      = 8'h00;
  localparam logic [7:0] OFF_TX_POLL       = 8'h08;
  localparam logic [7:0] OFF_RX_POLL       = 8'h10;
  localparam logic [7:0] OFF_RX_LIST       = 8'h18;
  localparam logic [7:0] OFF_TX_LIST       = 8'h20;
  localparam logic [7:0] OFF_STATUS        = 8'h28;
  localparam logic [7:0] OFF_OP_MODE       = 8'h30;
  localparam logic [7:0] OFF_INT_ENABLE    = 8'h38;
  localparam logic [7:0] OFF_MISSED        = 8'h40;
  localparam logic [7:0] OFF_ROM_MGMT      = 8'h48;
  localparam logic [7:0] OFF_ROM_ADDR      = 8'h50;
  localparam logic [7:0] OFF_TIMER         = 8'h58;
  localparam logic [7:0] OFF_GP_PORT       = 8'h60;
  localparam logic [7:0] OFF_RSVD_A        = 8'h68;
  localparam logic [7:0] OFF_RSVD_B        = 8'h70;
  localparam logic [7:0] OFF_WATCHDOG      = 8'h78;
  localparam logic [7:0] OFF_LAST          = OFF_WATCHDOG;
  localparam int unsigned OFF_LSB          = 3;   // quadword spacing
  localparam int unsigned OFF_ALIGN_W      = 3;
  localparam int unsigned OFF_W            = 8;
  // Power/driver area register fields
  localparam int unsigned SLEEP_BIT        = 31;
  localparam int unsigned SNOOZE_BIT       = 30;
  localparam int unsigned DRV_LSB          = 8;
  localparam int unsigned DRV_MSB          = 15;
  localparam logic [31:0] PDA_RESET        = 32'h0000_0000;
  localparam logic [31:0] CSR_RESET        = 32'h0000_0000;
  // Memory base: block base in 31:7, bit 0 reads zero
  localparam int unsigned MEMBASE_LSB      = 7;
  localparam int unsigned IOBASE_LSB       = 7;
  // Access kinds of the host bus
  typedef enum logic [1:0] {
    SPACE_CFG = 2'b00,
    SPACE_IO  = 2'b01,
    SPACE_MEM = 2'b10
  } space_t;
  // Completion codes returned to the host
  typedef enum logic [1:0] {
    RESP_OK     = 2'b00,
    RESP_RETRY  = 2'b01,
    RESP_IGNORE = 2'b10
  } resp_t;
  localparam int unsigned WAKE_HOLD = 4;  // cycles awake after last activity
  localparam int unsigned WAKE_W    = 3;
endpackage

/* File: csr_link_if.sv */
// Host-to-device register access link: one request at a time, answered on the next cycle.
// Assumes both ends share ref_clk; the testbench joins the modports.
`timescale 1ns/1ps
`default_nettype none
interface csr_link_if;
  logic                   req;       // access request, level while pending
  csr_pkg::space_t        space;     // configuration, io or memory
  logic                   write;     // 1 write, 0 read
  logic                   burst;     // this is a later data phase of a burst
  logic            [31:0] addr;      // host address (config: register offset)
  logic            [31:0] wdata;
  logic                   ack;       // answer valid, one-cycle pulse
  csr_pkg::resp_t         resp;
  logic            [31:0] rdata;
  modport device (input req, space, write, burst, addr, wdata,
                  output ack, resp, rdata);
  modport host   (output req, space, write, burst, addr, wdata,
                  input ack, resp, rdata);
endinterface
`default_nettype wire

/* File: csr_decode.sv */
// Offset decode shared by the device: maps an address to a CSR index.
// Assumes the base register already holds a block-aligned base.
`timescale 1ns/1ps
`default_nettype none
module csr_decode #(
  parameter int unsigned BASE_LSB = csr_pkg::MEMBASE_LSB
) (
  input  wire logic [31:0] addr,
  input  wire logic [31:0] base,
  output logic             hit,
  output logic             aligned,
  output logic [3:0]       index
);
  logic [csr_pkg::OFF_W-1:0] off;
  initial begin
    if (BASE_LSB < csr_pkg::OFF_W - 1) $error("base too fine for the block");
  end
  always_comb begin
    hit     = (addr[31:BASE_LSB] == base[31:BASE_LSB]);
    off     = addr[csr_pkg::OFF_W-1:0] - base[csr_pkg::OFF_W-1:0];
    aligned = (off[csr_pkg::OFF_ALIGN_W-1:0] == 3'b000) && (off <= csr_pkg::OFF_LAST);
    index   = off[csr_pkg::OFF_LSB +: csr_pkg::CSR_IDX_W];
  end
endmodule
`default_nettype wire

/* File: csr_device.sv */
// Device end: power/driver area register, base registers and CSR bank.
// Assumes host keeps sleep and snooze apart and uses whole longwords.
`timescale 1ns/1ps
`default_nettype none
module csr_device #(
  parameter int unsigned WAKE_HOLD = csr_pkg::WAKE_HOLD
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  csr_link_if.device       link,
  input  wire logic        net_activity,   // receive line activity seen
  input  wire logic        tx_start,       // transmission started
  output logic             clk_gate_en,    // 1: internal clocks running
  output logic             sleeping,
  output logic             snoozing,
  output logic [7:0]       driver_byte,
  output logic [31:0]      bus_mode_q      // bus mode register contents
);
  initial begin
    if (WAKE_HOLD < 1 || WAKE_HOLD >= (1 << csr_pkg::WAKE_W))
      $error("WAKE_HOLD out of range");
  end

  typedef struct packed {
    logic [31:0]                        pda;
    logic [31:0]                        io_base;
    logic [31:0]                        mem_base;
    logic [csr_pkg::CSR_COUNT-1:0][31:0] csr;
    logic [csr_pkg::WAKE_W-1:0]         wake_cnt;
    logic                               ack;
    csr_pkg::resp_t                     resp;
    logic [31:0]                        rdata;
  } state_t;

  state_t st;
  state_t next_st;

  logic       io_hit;
  logic       io_al;
  logic [3:0] io_idx;
  logic       mem_hit;
  logic       mem_al;
  logic [3:0] mem_idx;

  // Two decoders, one per base register
  csr_decode #(.BASE_LSB(csr_pkg::IOBASE_LSB)) u_io_dec (
    .addr    (link.addr),
    .base    (st.io_base),
    .hit     (io_hit),
    .aligned (io_al),
    .index   (io_idx)
  );
  csr_decode #(.BASE_LSB(csr_pkg::MEMBASE_LSB)) u_mem_dec (
    .addr    (link.addr),
    .base    (st.mem_base),
    .hit     (mem_hit),
    .aligned (mem_al),
    .index   (mem_idx)
  );

  // Configuration registers by offset; only the ones this block keeps
  localparam logic [7:0] CFG_IO_BASE  = 8'h10;
  localparam logic [7:0] CFG_MEM_BASE = 8'h14;
  localparam logic [7:0] CFG_PDA      = 8'h40;

  logic sleep_on;
  logic snooze_on;
  logic awake_evt;
  logic csr_space;
  logic csr_hit;
  logic csr_al;
  logic [3:0] csr_idx;

  always_comb begin
    sleep_on  = st.pda[csr_pkg::SLEEP_BIT];
    snooze_on = st.pda[csr_pkg::SNOOZE_BIT];
    csr_space = (link.space == csr_pkg::SPACE_IO) || (link.space == csr_pkg::SPACE_MEM);
    csr_hit   = (link.space == csr_pkg::SPACE_IO) ? io_hit : mem_hit;
    csr_al    = (link.space == csr_pkg::SPACE_IO) ? io_al : mem_al;
    csr_idx   = (link.space == csr_pkg::SPACE_IO) ? io_idx : mem_idx;
    awake_evt = net_activity || tx_start || (link.req && csr_space && csr_hit);
  end

  // Next-state logic: host access, power mode and wake hold
  always_comb begin
    next_st       = st;
    next_st.ack   = 1'b0;
    next_st.resp  = csr_pkg::RESP_OK;
    next_st.rdata = 32'h0000_0000;

    if (awake_evt) begin
      next_st.wake_cnt = csr_pkg::WAKE_W'(WAKE_HOLD);
    end else if (st.wake_cnt != '0) begin
      next_st.wake_cnt = st.wake_cnt - 1'b1;
    end

    if (link.req && !st.ack) begin
      next_st.ack = 1'b1;
      if (link.space == csr_pkg::SPACE_CFG) begin
        unique case (link.addr[7:0])
          CFG_IO_BASE: begin
            next_st.rdata = {st.io_base[31:csr_pkg::IOBASE_LSB], 7'h01};
            if (link.write)
              next_st.io_base = {link.wdata[31:csr_pkg::IOBASE_LSB], 7'h00};
          end
          CFG_MEM_BASE: begin
            // Base in 31:7, bit 0 zero
            next_st.rdata = {st.mem_base[31:csr_pkg::MEMBASE_LSB], 7'h00};
            if (link.write)
              next_st.mem_base = {link.wdata[31:csr_pkg::MEMBASE_LSB], 7'h00};
          end
          CFG_PDA: begin
            next_st.rdata = st.pda;
            if (link.write) begin
              next_st.pda = 32'h0000_0000;
              next_st.pda[csr_pkg::SLEEP_BIT]  = link.wdata[csr_pkg::SLEEP_BIT];
              next_st.pda[csr_pkg::SNOOZE_BIT] = link.wdata[csr_pkg::SNOOZE_BIT];
              next_st.pda[csr_pkg::DRV_MSB:csr_pkg::DRV_LSB] =
                link.wdata[csr_pkg::DRV_MSB:csr_pkg::DRV_LSB];
            end
          end
          default: next_st.rdata = 32'h0000_0000;
        endcase
      end else if (sleep_on || !csr_hit) begin
        next_st.resp = csr_pkg::RESP_IGNORE;
      end else if (link.burst) begin
        next_st.resp = csr_pkg::RESP_RETRY;
      end else if (csr_al) begin
        next_st.rdata = st.csr[csr_idx];
        if (link.write)
          next_st.csr[csr_idx] = link.wdata;
      end
      // Misaligned falls through: zero read, write dropped
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st.pda      <= csr_pkg::PDA_RESET;
      st.io_base  <= 32'h0000_0000;
      st.mem_base <= 32'h0000_0000;
      st.csr      <= '0;
      st.wake_cnt <= '0;
      st.ack      <= 1'b0;
      st.resp     <= csr_pkg::RESP_OK;
      st.rdata    <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // Answer and power outputs; clocks gated always in sleep, and in snooze when idle
  assign link.ack    = st.ack;
  assign link.resp   = st.resp;
  assign link.rdata  = st.rdata;
  assign sleeping    = sleep_on;
  assign snoozing    = snooze_on && (st.wake_cnt == '0);
  assign clk_gate_en = !sleep_on && !(snooze_on && st.wake_cnt == '0);
  assign driver_byte = st.pda[csr_pkg::DRV_MSB:csr_pkg::DRV_LSB];
  assign bus_mode_q  = st.csr[0];
endmodule
`default_nettype wire

/* File: csr_host.sv */
// Host end: turns one user command into one link access and returns data.
// Assumes the device answers each request with one ack pulse.
`timescale 1ns/1ps
`default_nettype none
module csr_host (
  input  wire logic            ref_clk,
  input  wire logic            nrst,
  csr_link_if.host             link,
  input  wire logic            cmd_valid,  // one-cycle command pulse
  output logic                 cmd_ready,
  input  wire csr_pkg::space_t cmd_space,
  input  wire logic            cmd_write,
  input  wire logic            cmd_burst,
  input  wire logic [31:0]     cmd_addr,
  input  wire logic [31:0]     cmd_wdata,
  output logic                 done,
  output csr_pkg::resp_t       done_resp,
  output logic [31:0]          done_rdata
);
  typedef enum logic [0:0] { H_IDLE = 1'b0, H_WAIT = 1'b1 } hstate_t;
  typedef struct packed {
    hstate_t         fsm;
    csr_pkg::space_t space;
    logic            write;
    logic            burst;
    logic [31:0]     addr;
    logic [31:0]     wdata;
    logic            done;
    csr_pkg::resp_t  resp;
    logic [31:0]     rdata;
  } hst_t;
  hst_t st;
  hst_t next_st;
  logic [31:0] safe_wdata;

  // Never both sleep and snooze on config writes; other bits pass unchanged
  always_comb begin
    safe_wdata = cmd_wdata;
    if (cmd_space == csr_pkg::SPACE_CFG && cmd_wdata[csr_pkg::SLEEP_BIT])
      safe_wdata[csr_pkg::SNOOZE_BIT] = 1'b0;
  end

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    unique case (st.fsm)
      H_IDLE: begin
        if (cmd_valid) begin
          next_st.fsm   = H_WAIT;
          next_st.space = cmd_space;
          // Drop writes to second reserved slot
          next_st.write = cmd_write &&
            !(cmd_space != csr_pkg::SPACE_CFG &&
              cmd_addr[7:0] == csr_pkg::OFF_RSVD_B);
          next_st.burst = cmd_burst;
          // Config offsets are longword spaced, so only CSR space is cut
          next_st.addr  = (cmd_space == csr_pkg::SPACE_CFG) ? cmd_addr :
                          {cmd_addr[31:csr_pkg::OFF_ALIGN_W], 3'b000};
          next_st.wdata = safe_wdata;
        end
      end
      H_WAIT: begin
        if (link.ack) begin
          next_st.fsm   = H_IDLE;
          next_st.done  = 1'b1;
          next_st.resp  = link.resp;
          next_st.rdata = link.rdata;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '{fsm: H_IDLE, space: csr_pkg::SPACE_CFG, resp: csr_pkg::RESP_OK,
              default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign link.req    = (st.fsm == H_WAIT) && !link.ack;
  assign link.space  = st.space;
  assign link.write  = st.write;
  assign link.burst  = st.burst;
  assign link.addr   = st.addr;
  assign link.wdata  = st.wdata;
  assign cmd_ready   = (st.fsm == H_IDLE);
  assign done        = st.done;
  assign done_resp   = st.resp;
  assign done_rdata  = st.rdata;
endmodule
`default_nettype wire

/* File: csr_link_assertions.sv */
// Concurrent checks on the register link between host end and device end.
// Assumes it watches one link whose two ends share ref_clk and nrst.
`timescale 1ns/1ps
`default_nettype none
module csr_link_assertions (
  input wire logic            ref_clk,
  input wire logic            nrst,
  input wire logic            req,
  input wire csr_pkg::space_t space,
  input wire logic            write,
  input wire logic            burst,
  input wire logic [31:0]     addr,
  input wire logic            ack,
  input wire csr_pkg::resp_t  resp,
  input wire logic [31:0]     rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Request taken by the device at this edge
  sequence s_take;
    req && !ack;
  endsequence
  // Single configuration read of one offset
  sequence s_cfg_rd(o);
    s_take ##0 (!burst && !write && space == csr_pkg::SPACE_CFG && addr[7:0] == o);
  endsequence
  property p_ack_next; s_take |=> ack; endproperty
  property p_ack_pulse; ack |=> !ack; endproperty
  property p_ack_cause; ack |-> $past(req); endproperty
  // CSR space only; asleep, ignore outranks retry
  property p_burst_retry;
    s_take ##0 (burst && space != csr_pkg::SPACE_CFG) |=>
      (resp == csr_pkg::RESP_RETRY || resp == csr_pkg::RESP_IGNORE);
  endproperty
  property p_ignore_zero; ack && resp == csr_pkg::RESP_IGNORE |-> rdata == '0; endproperty
  property p_cfg_served;
    s_take ##0 (space == csr_pkg::SPACE_CFG && !burst) |=> resp == csr_pkg::RESP_OK;
  endproperty
  property p_pda_clear; s_cfg_rd(8'h40) |=> rdata[29:16] == '0 && rdata[7:0] == '0; endproperty
  property p_mem_low; s_cfg_rd(8'h14) |=> rdata[6:0] == '0; endproperty
  // Config offsets are longword spaced, so only CSR space is checked
  property p_aligned; req && space != csr_pkg::SPACE_CFG |-> addr[2:0] == 3'h0; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("answer held longer than one cycle");
  a_ack_cause: assert property (p_ack_cause)
    else $error("answer without request");
  a_burst_retry: assert property (p_burst_retry)
    else $error("later burst phase not retried");
  a_ignore_zero: assert property (p_ignore_zero)
    else $error("ignored access returned data");
  a_cfg_served: assert property (p_cfg_served)
    else $error("configuration access not served");
  a_pda_clear: assert property (p_pda_clear)
    else $error("undefined power bits read nonzero");
  a_mem_low: assert property (p_mem_low)
    else $error("memory base low bits nonzero");
  a_aligned: assert property (p_aligned)
    else $error("request not quadword aligned");
endmodule
`default_nettype wire

/* File: power_mode_and_csr_decode_tb_top.sv */
// Testbench: host end and device end joined by the link, driven by commands.
// Assumes a 25 MHz ref_clk and a short wake hold after snooze activity.
`timescale 1ns/1ps
`default_nettype none
module power_mode_and_csr_decode_tb_top;
  localparam csr_pkg::space_t CF = csr_pkg::SPACE_CFG;
  localparam csr_pkg::space_t IO = csr_pkg::SPACE_IO;
  localparam csr_pkg::space_t MM = csr_pkg::SPACE_MEM;
  localparam csr_pkg::resp_t  OK = csr_pkg::RESP_OK;
  localparam csr_pkg::resp_t  RT = csr_pkg::RESP_RETRY;
  localparam csr_pkg::resp_t  IG = csr_pkg::RESP_IGNORE;
  logic            ref_clk, nrst, cmd_valid, cmd_ready, cmd_write, cmd_burst, done;
  logic            net_activity, tx_start, clk_gate_en, sleeping, snoozing;
  logic [31:0]     cmd_addr, cmd_wdata, done_rdata, bus_mode_q;
  logic [7:0]      driver_byte;
  csr_pkg::space_t cmd_space;
  csr_pkg::resp_t  done_resp;
  int              miscompares, compares;
  csr_link_if link ();
  csr_device i_csr_device (.ref_clk(ref_clk), .nrst(nrst), .link(link.device),
    .net_activity(net_activity), .tx_start(tx_start), .clk_gate_en(clk_gate_en),
    .sleeping(sleeping), .snoozing(snoozing), .driver_byte(driver_byte),
    .bus_mode_q(bus_mode_q));
  csr_host i_csr_host (.ref_clk(ref_clk), .nrst(nrst), .link(link.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_space(cmd_space),
    .cmd_write(cmd_write), .cmd_burst(cmd_burst), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .done(done), .done_resp(done_resp), .done_rdata(done_rdata));
  csr_link_assertions i_csr_link_assertions (.ref_clk(ref_clk), .nrst(nrst),
    .req(link.req), .space(link.space), .write(link.write), .burst(link.burst),
    .addr(link.addr), .ack(link.ack), .resp(link.resp), .rdata(link.rdata));
  // Free-running bus clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Counts, verdict, stop
  task automatic end_sim();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Wait k edges, then step off the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // One host command; bounded wait on done, then check response and read data
  task automatic acc(input csr_pkg::space_t sp, input logic w, input logic b,
                     input logic [31:0] a, input logic [31:0] d,
                     input csr_pkg::resp_t er, input logic [31:0] ed);
    int n = 0;
    cyc(1);
    cmd_valid = 1'b1;
    cmd_space = sp;
    cmd_write = w;
    cmd_burst = b;
    cmd_addr = a;
    cmd_wdata = d;
    cyc(1);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    if (done !== 1'b1) begin
      miscompares++;
      end_sim();
    end
    chk({30'h0000_0000, done_resp}, {30'h0000_0000, er});
    if (!w) chk(done_rdata, ed);
  endtask
  initial begin
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd_space = CF;
    cmd_write = 1'b0;
    cmd_burst = 1'b0;
    cmd_addr = 32'h0000_0000;
    cmd_wdata = 32'h0000_0000;
    net_activity = 1'b0;
    tx_start = 1'b0;
    miscompares = 0;
    compares = 0;
    cyc(10);
    nrst = 1'b1;
    // Reset values, then the two base registers
    acc(CF, 0, 0, 32'h0000_0040, 0, OK, 32'h0000_0000);
    chk({31'h0, clk_gate_en}, 32'h0000_0001);
    chk({31'h0, cmd_ready}, 32'h0000_0001);
    acc(CF, 1, 0, 32'h0000_0014, 32'h0000_107F, OK, 0);
    acc(CF, 1, 0, 32'h0000_0010, 32'h0000_2000, OK, 0);
    acc(CF, 0, 0, 32'h0000_0014, 0, OK, 32'h0000_1000);
    acc(CF, 0, 0, 32'h0000_0010, 0, OK, 32'h0000_2001);
    $display("test bases done");
    // Every slot written through memory, read back through io; 0x70 left unwritten
    for (int i = 0; i < 16; i++) begin
      if (i != 14) acc(MM, 1, 0, 32'h0000_1000 + 32'(i * 8), 32'hC0DE_0000 + 32'(i), OK, 0);
      acc(IO, 0, 0, 32'h0000_2000 + 32'(i * 8), 0, OK, (i == 14) ? 0 : 32'hC0DE_0000 + 32'(i));
    end
    chk(bus_mode_q, 32'hC0DE_0000);
    $display("test bank done");
    // Burst phase retried and not written; address outside the block ignored
    acc(MM, 1, 1, 32'h0000_1008, 32'hFFFF_FFFF, RT, 0);
    acc(MM, 0, 0, 32'h0000_1008, 0, OK, 32'hC0DE_0001);
    acc(MM, 0, 0, 32'h0000_3008, 0, IG, 32'h0000_0000);
    $display("test refusals done");
    // Driver byte is plain storage
    acc(CF, 1, 0, 32'h0000_0040, 32'h0000_A500, OK, 0);
    acc(CF, 0, 0, 32'h0000_0040, 0, OK, 32'h0000_A500);
    chk({24'h00_0000, driver_byte}, 32'h0000_00A5);
    $display("test driver byte done");
    // Snooze: idle gates clocks, activity wakes them for a while
    acc(CF, 1, 0, 32'h0000_0040, 32'h4000_A500, OK, 0);
    cyc(10);
    chk({31'h0, snoozing}, 32'h0000_0001);
    chk({31'h0, clk_gate_en}, 32'h0000_0000);
    net_activity = 1'b1;
    cyc(2);
    chk({31'h0, clk_gate_en}, 32'h0000_0001);
    net_activity = 1'b0;
    cyc(10);
    chk({31'h0, clk_gate_en}, 32'h0000_0000);
    tx_start = 1'b1;
    cyc(2);
    chk({31'h0, clk_gate_en}, 32'h0000_0001);
    tx_start = 1'b0;
    cyc(10);
    acc(MM, 0, 0, 32'h0000_1000, 0, OK, 32'hC0DE_0000);
    chk({31'h0, clk_gate_en}, 32'h0000_0001);
    acc(CF, 1, 0, 32'h0000_0040, 32'h0000_A500, OK, 0);
    cyc(10);
    chk({30'h0, snoozing, clk_gate_en}, 32'h0000_0001);
    $display("test snooze done");
    // Sleep: only configuration space is served, CSR space answered with ignore, until the bit is cleared
    acc(CF, 1, 0, 32'h0000_0040, 32'hC000_0000, OK, 0);
    cyc(2);
    chk({30'h0, sleeping, clk_gate_en}, 32'h0000_0002);
    acc(MM, 0, 0, 32'h0000_1000, 0, IG, 32'h0000_0000);
    acc(CF, 0, 0, 32'h0000_0040, 0, OK, 32'h8000_0000);
    acc(CF, 1, 0, 32'h0000_0040, 32'h0000_0000, OK, 0);
    cyc(2);
    chk({30'h0, sleeping, clk_gate_en}, 32'h0000_0001);
    acc(MM, 0, 0, 32'h0000_1000, 0, OK, 32'hC0DE_0000);
    $display("test sleep done");
    // Hardware reset in mid sleep
    acc(CF, 1, 0, 32'h0000_0040, 32'h8000_0000, OK, 0);
    nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
    chk({30'h0, sleeping, clk_gate_en}, 32'h0000_0001);
    acc(CF, 0, 0, 32'h0000_0040, 0, OK, 32'h0000_0000);
    $display("test reset done");
    end_sim();
  end
endmodule
`default_nettype wire
